// ### logic/sifd_decoder.sv
// module: digital input function decoder with wishbone registers
//
// Overview of operation
// - step input runs step amount while servo running, else lock
// - two inputs pick x10, x100, else x1
// - wheel enabled only while input active
// - gear ratio two while select active
// - torque, speed forward when select active
// - position direction inverted when input inactive
// - multi-position edge input enables, else locked
// - unlock input releases on-the-fly latch
// - without unlock, latch held, references ignored
// - origin sensor active marks home position
// - level-only: rise to high, fall to low
// - level-only: both edges becomes low level
// - search start ignored while search running
// - block input prohibits on-the-fly changes
// - halt input stops and holds position
// - deviation clear input clears accumulated deviation
// - source two, select active: first cap
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module sifd_decoder (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic [8:0]               di_pin,
  input  wire logic                     xint_trigger,
  input  wire logic                     origin_search_done,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  output sifd_pkg::sifd_cmd_t           cmd,
  output logic      [31:0]              step_amount,
  output logic      [15:0]              velocity_cap
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  sifd_pkg::sifd_assign_t assign_reg [sifd_pkg::NUM_DI];
  logic [31:0] step_amount_param;
  logic [15:0] velocity_cap_first_param;
  logic [15:0] velocity_cap_second_param;
  logic [1:0]  velocity_cap_source_param;
  logic        servo_running;

  // ----------------------------------------------------------------
  // terminal logic coercion and function gather
  // ----------------------------------------------------------------
  logic [sifd_pkg::NUM_DI-1:0] term_active;
  logic [2:0] eff_logic [sifd_pkg::NUM_DI];
  logic [sifd_pkg::NUM_FUNC-1:0] func_act;

  function automatic logic level_only(input logic [5:0] f);
    level_only = (f == sifd_pkg::FN_ORIGIN) || (f == sifd_pkg::FN_BLOCK);
  endfunction

  function automatic logic [2:0] coerce(input logic [2:0] s);
    unique case (s)
      sifd_pkg::LOGIC_RISE: coerce = sifd_pkg::LOGIC_HIGH;
      sifd_pkg::LOGIC_FALL: coerce = sifd_pkg::LOGIC_LOW;
      sifd_pkg::LOGIC_BOTH: coerce = sifd_pkg::LOGIC_LOW;
      default:              coerce = s;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < sifd_pkg::NUM_DI; gi++) begin : g_term
      assign eff_logic[gi] = level_only(assign_reg[gi].func) ?
        coerce(assign_reg[gi].logic_sel) : assign_reg[gi].logic_sel;
      sifd_terminal u_term (
        .clk       (clk),
        .reset     (reset),
        .pin       (di_pin[gi]),
        .logic_sel (eff_logic[gi]),
        .active    (term_active[gi])
      );
    end
  endgenerate

  // several terminals may share a function; any active one wins
  always_comb begin
    func_act = '0;
    for (int t = 0; t < sifd_pkg::NUM_DI; t++) begin
      for (int f = 0; f < sifd_pkg::NUM_FUNC; f++) begin
        if (assign_reg[t].func == 6'(f + sifd_pkg::FUNC_LO) && term_active[t])
          func_act[f] = 1'b1;
      end
    end
  end

  function automatic logic fa(input logic [5:0] fn);
    fa = func_act[5'(fn - 6'(sifd_pkg::FUNC_LO))];
  endfunction

  // ----------------------------------------------------------------
  // decoded commands
  // ----------------------------------------------------------------
  // a continuous assignment only wakes on its operands, not on what a
  // function reads behind them, so these index func_act directly
  localparam int IX_SCALE_A = int'(sifd_pkg::FN_SCALE_A) - sifd_pkg::FUNC_LO;
  localparam int IX_SCALE_B = int'(sifd_pkg::FN_SCALE_B) - sifd_pkg::FUNC_LO;
  localparam int IX_VCAP    = int'(sifd_pkg::FN_VCAP) - sifd_pkg::FUNC_LO;
  localparam int IX_RELEASE = int'(sifd_pkg::FN_RELEASE) - sifd_pkg::FUNC_LO;
  localparam int IX_BLOCK   = int'(sifd_pkg::FN_BLOCK) - sifd_pkg::FUNC_LO;
  localparam int IX_SEARCH  = int'(sifd_pkg::FN_SEARCH) - sifd_pkg::FUNC_LO;
  wire act_a = func_act[IX_SCALE_A];
  wire act_b = func_act[IX_SCALE_B];
  wire [1:0] next_scale =
    (act_a & ~act_b) ? sifd_pkg::SCALE_X10 :
    (~act_a & act_b) ? sifd_pkg::SCALE_X100 :
    sifd_pkg::SCALE_X1;
  wire vcap_di = velocity_cap_source_param == sifd_pkg::VCAP_SRC_DI;
  wire [15:0] next_cap = (vcap_di & func_act[IX_VCAP]) ?
    velocity_cap_first_param :
    velocity_cap_second_param;
  // latch stays until released; trigger sets it unless blocked
  wire next_locked =
    func_act[IX_RELEASE] ? 1'b0 :
    (xint_trigger & ~func_act[IX_BLOCK]) ? 1'b1 :
    cmd.move_locked;
  wire search_req = func_act[IX_SEARCH];
  wire next_start = search_req & ~cmd.searching;
  // set wins over the done clear
  wire next_searching = next_start |
    (cmd.searching & ~origin_search_done);
  logic multi_on;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      multi_on <= 1'b0;
    end else begin
      multi_on <= fa(sifd_pkg::FN_MULTI);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd          <= '0;
      velocity_cap <= '0;
      step_amount  <= '0;
    end else begin
      cmd.step_run        <= servo_running & fa(sifd_pkg::FN_STEP);
      cmd.wheel_scale     <= next_scale;
      cmd.wheel_on        <= fa(sifd_pkg::FN_WHEEL);
      cmd.gear_two        <= fa(sifd_pkg::FN_GEAR);
      cmd.torque_fwd      <= fa(sifd_pkg::FN_TORQUE);
      cmd.velocity_fwd    <= fa(sifd_pkg::FN_VELOCITY);
      cmd.position_invert <= ~fa(sifd_pkg::FN_POSITION);
      cmd.multi_on        <= multi_on;
      cmd.move_locked     <= next_locked;
      cmd.origin_hit      <= fa(sifd_pkg::FN_ORIGIN);
      cmd.search_start    <= next_start;
      cmd.searching       <= next_searching;
      cmd.move_blocked    <= fa(sifd_pkg::FN_BLOCK);
      cmd.halt_hold       <= fa(sifd_pkg::FN_HALT);
      cmd.deviation_clear <= fa(sifd_pkg::FN_DEVCLR);
      velocity_cap        <= next_cap;
      step_amount         <= cmd.step_run ? step_amount_param : '0;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave, one wait-free ack per access
  // ----------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr  = req & wb_we_i;
  wire in_assign = wb_adr_i < 8'(4 * sifd_pkg::NUM_DI);
  wire [3:0] aidx = wb_adr_i[5:2];
  wire hit_ctrl = wb_adr_i == sifd_pkg::ADDR_CTRL;
  wire hit_cap1 = wb_adr_i == sifd_pkg::ADDR_VCAP1;
  wire hit_cap2 = wb_adr_i == sifd_pkg::ADDR_VCAP2;
  wire hit_stat = wb_adr_i == sifd_pkg::ADDR_STATUS;
  wire hit_step = wb_adr_i == sifd_pkg::ADDR_STEP;
  wire [31:0] assign_word = in_assign ?
    {21'h0, assign_reg[aidx].logic_sel, 2'h0, assign_reg[aidx].func} :
    32'h0;
  wire [31:0] ctrl_word = {26'h0, velocity_cap_source_param,
    3'h0, servo_running};
  wire [31:0] stat_word = {7'h0, func_act, 8'h0};
  wire [31:0] next_rdata =
    in_assign ? assign_word :
    hit_ctrl  ? ctrl_word :
    hit_cap1  ? {16'h0, velocity_cap_first_param} :
    hit_cap2  ? {16'h0, velocity_cap_second_param} :
    hit_stat  ? stat_word :
    hit_step  ? step_amount_param :
    32'h0;  // unmapped reads as zero, writes dropped

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? next_rdata : '0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < sifd_pkg::NUM_DI; i++) begin
        assign_reg[i] <= '0;
      end
      step_amount_param         <= '0;
      velocity_cap_first_param  <= '0;
      velocity_cap_second_param <= '0;
      velocity_cap_source_param <= '0;
      servo_running             <= 1'b0;
    end else if (wr) begin
      if (in_assign && wb_sel_i[0]) begin
        assign_reg[aidx].func <= wb_dat_i[5:0];
      end
      if (in_assign && wb_sel_i[1]) begin
        assign_reg[aidx].logic_sel <= wb_dat_i[10:8];
      end
      if (hit_ctrl && wb_sel_i[0]) begin
        servo_running             <= wb_dat_i[0];
        velocity_cap_source_param <= wb_dat_i[5:4];
      end
      if (hit_cap1 && wb_sel_i[0]) begin
        velocity_cap_first_param[7:0] <= wb_dat_i[7:0];
      end
      if (hit_cap1 && wb_sel_i[1]) begin
        velocity_cap_first_param[15:8] <= wb_dat_i[15:8];
      end
      if (hit_cap2 && wb_sel_i[0]) begin
        velocity_cap_second_param[7:0] <= wb_dat_i[7:0];
      end
      if (hit_cap2 && wb_sel_i[1]) begin
        velocity_cap_second_param[15:8] <= wb_dat_i[15:8];
      end
      for (int b = 0; b < 4; b++) begin
        if (hit_step && wb_sel_i[b]) begin
          step_amount_param[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

endmodule

// ### logic/sifd_terminal.sv
// module: one terminal, polarity and edge detection
`timescale 1ns/100ps
module sifd_terminal (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       pin,
  input  wire logic [2:0] logic_sel,
  output logic            active
);
  logic sync_a;
  logic sync_b;
  logic prev;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire rise = sync_b & ~prev;
  wire fall = ~sync_b & prev;
  wire next_active =
    (logic_sel == sifd_pkg::LOGIC_HIGH) ? sync_b :
    (logic_sel == sifd_pkg::LOGIC_RISE) ? rise :
    (logic_sel == sifd_pkg::LOGIC_FALL) ? fall :
    (logic_sel == sifd_pkg::LOGIC_BOTH) ? (rise | fall) :
    ~sync_b;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
      active <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      prev   <= sync_b;
      active <= next_active;
    end
  end
endmodule

// ### shared/sifd_pkg.sv
// package: constants, types for the servo input function decoder
package sifd_pkg;

  // ----------------------------------------------------------------
  // terminal logic settings
  // ----------------------------------------------------------------
  localparam logic [2:0] LOGIC_LOW   = 3'h0;
  localparam logic [2:0] LOGIC_HIGH  = 3'h1;
  localparam logic [2:0] LOGIC_RISE  = 3'h2;
  localparam logic [2:0] LOGIC_FALL  = 3'h3;
  localparam logic [2:0] LOGIC_BOTH  = 3'h4;

  // ----------------------------------------------------------------
  // terminals and function numbers
  // ----------------------------------------------------------------
  localparam int NUM_DI   = 9;
  localparam int FUNC_LO  = 20;
  localparam int FUNC_HI  = 36;
  localparam int NUM_FUNC = 17;

  localparam logic [5:0] FN_STEP     = 6'h14;
  localparam logic [5:0] FN_SCALE_A  = 6'h15;
  localparam logic [5:0] FN_SCALE_B  = 6'h16;
  localparam logic [5:0] FN_WHEEL    = 6'h17;
  localparam logic [5:0] FN_GEAR     = 6'h18;
  localparam logic [5:0] FN_TORQUE   = 6'h19;
  localparam logic [5:0] FN_VELOCITY = 6'h1a;
  localparam logic [5:0] FN_POSITION = 6'h1b;
  localparam logic [5:0] FN_MULTI    = 6'h1c;
  localparam logic [5:0] FN_RELEASE  = 6'h1d;
  localparam logic [5:0] FN_ORIGIN   = 6'h1f;
  localparam logic [5:0] FN_SEARCH   = 6'h20;
  localparam logic [5:0] FN_BLOCK    = 6'h21;
  localparam logic [5:0] FN_HALT     = 6'h22;
  localparam logic [5:0] FN_DEVCLR   = 6'h23;
  localparam logic [5:0] FN_VCAP     = 6'h24;

  // ----------------------------------------------------------------
  // multiplier codes, speed-limit source
  // ----------------------------------------------------------------
  localparam logic [1:0] SCALE_X1   = 2'h0;
  localparam logic [1:0] SCALE_X10  = 2'h1;
  localparam logic [1:0] SCALE_X100 = 2'h2;
  localparam logic [1:0] VCAP_SRC_DI = 2'h2;

  // ----------------------------------------------------------------
  // register map (wishbone byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ASSIGN = 8'h00;  // 9 words, one per terminal
  localparam logic [7:0] ADDR_CTRL   = 8'h40;
  localparam logic [7:0] ADDR_VCAP1  = 8'h44;
  localparam logic [7:0] ADDR_VCAP2  = 8'h48;
  localparam logic [7:0] ADDR_STATUS = 8'h4c;
  localparam logic [7:0] ADDR_STEP   = 8'h50;
  localparam int ASSIGN_FN_LSB  = 0;
  localparam int ASSIGN_LOG_LSB = 8;
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_DONE_BIT  = 1;
  localparam int CTRL_SRC_LSB   = 4;

  typedef struct packed {
    logic [5:0] func;
    logic [2:0] logic_sel;
  } sifd_assign_t;

  typedef struct packed {
    logic        step_run;
    logic [1:0]  wheel_scale;
    logic        wheel_on;
    logic        gear_two;
    logic        torque_fwd;
    logic        velocity_fwd;
    logic        position_invert;
    logic        multi_on;
    logic        move_locked;
    logic        origin_hit;
    logic        search_start;
    logic        searching;
    logic        move_blocked;
    logic        halt_hold;
    logic        deviation_clear;
  } sifd_cmd_t;

endpackage

// ### test/sifd_monitor.sv
// checker: bus handshake and command relations of the decoder
`timescale 1ns/100ps
module sifd_monitor (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire sifd_pkg::sifd_cmd_t cmd,
  input wire logic [31:0]         step_amount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  // ----------------------------------------------------------------
  // command relations
  // ----------------------------------------------------------------
  scale_code_a: assert property (cmd.wheel_scale != 2'h3)
    else $error("illegal multiplier code");
  step_zero_a: assert property (!cmd.step_run |=> step_amount == 32'h0)
    else $error("step amount while step idle");
  start_pulse_a: assert property (cmd.search_start |=> !cmd.search_start)
    else $error("search start longer than one cycle");
  search_run_a: assert property (cmd.search_start |=> cmd.searching)
    else $error("search not running after start");
endmodule

// ### test/sifd_switches.sv
// partner: switch bank driving the terminal pins
`timescale 1ns/100ps
module sifd_switches (
  input  wire logic       clk,
  input  wire logic [8:0] want,
  output logic      [8:0] di_pin
);
  // switches move on the sampling edge; a flop keeps races away
  always @(posedge clk) begin
    di_pin <= want;
  end
endmodule

// ### test/tb.sv
// testbench: decoder driven over wishbone and terminal pins
`timescale 1ns/100ps
module tb;
  logic                clk = 1'b0;
  logic                reset = 1'b1;
  logic [8:0]          want = 9'h0;
  logic [8:0]          di_pin;
  logic                done_p = 1'b0;
  logic                trig = 1'b0;
  logic                cyc = 1'b0;
  logic                stb = 1'b0;
  logic                we = 1'b0;
  logic [7:0]          adr = 8'h0;
  logic [31:0]         wdat = 32'h0;
  logic [31:0]         rdat;
  logic [31:0]         q;
  logic                ack;
  sifd_pkg::sifd_cmd_t cmd;
  logic [31:0]         step;
  logic [15:0]         vcap;
  int                  n_errors = 0;
  int                  checks_done = 0;
  int                  n_starts = 0;
  logic [5:0]          lv [10] = '{6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b,
                                   6'h1c, 6'h1f, 6'h21, 6'h22, 6'h23};
  logic [1:0]          scl [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  always #20 clk = ~clk;
  always @(posedge clk) if (cmd.search_start === 1'b1) n_starts++;
  sifd_switches SW (.clk(clk), .want(want), .di_pin(di_pin));
  sifd_decoder DUT (.clk(clk), .reset(reset), .di_pin(di_pin),
    .xint_trigger(trig), .origin_search_done(done_p), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cmd(cmd),
    .step_amount(step), .velocity_cap(vcap));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
    if (ack !== 1'b1) n_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic put(input int t, input logic [5:0] f, input logic [2:0] g);
    wb(1'b1, 8'(4 * t), {21'h0, g, 2'h0, f});
  endtask
  // pin path is up to six edges deep (multi_on, step_amount); eight leaves margin
  task automatic pins(input logic [8:0] v);
    want <= v;
    repeat (8) @(posedge clk);
  endtask
  function automatic logic fld(input logic [5:0] f);
    case (f)
      6'h17:   fld = cmd.wheel_on;
      6'h18:   fld = cmd.gear_two;
      6'h19:   fld = cmd.torque_fwd;
      6'h1a:   fld = cmd.velocity_fwd;
      6'h1b:   fld = cmd.position_invert;
      6'h1c:   fld = cmd.multi_on;
      6'h1f:   fld = cmd.origin_hit;
      6'h21:   fld = cmd.move_blocked;
      6'h22:   fld = cmd.halt_hold;
      default: fld = cmd.deviation_clear;
    endcase
  endfunction
  task automatic try(input logic [5:0] f, input logic [2:0] g, input logic a);
    logic [31:0] v;
    logic [31:0] e;
    put(0, f, g);
    for (int p = 0; p < 2; p++) begin
      pins({8'h0, p[0]});
      v = 32'(fld(f));
      e = 32'((p[0] == a) ^ (f == 6'h1b));
      chk(v, e);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (lv[i]) try(lv[i], sifd_pkg::LOGIC_HIGH, 1'b1);
    try(6'h17, sifd_pkg::LOGIC_LOW, 1'b0);
    for (int k = 0; k < 6; k++)
      try(k < 3 ? 6'h1f : 6'h21, 3'(2 + k % 3), k % 3 == 0);
    $display("level test done");
    put(1, sifd_pkg::FN_SCALE_B, sifd_pkg::LOGIC_HIGH);
    put(0, sifd_pkg::FN_SCALE_A, sifd_pkg::LOGIC_HIGH);
    for (int k = 0; k < 4; k++) begin
      pins(9'(k));
      chk(32'(cmd.wheel_scale), 32'(scl[k]));
    end
    $display("multiplier test done");
    wb(1'b1, sifd_pkg::ADDR_STEP, 32'h0001_2345);
    put(0, sifd_pkg::FN_STEP, sifd_pkg::LOGIC_HIGH);
    for (int r = 0; r < 2; r++) begin
      wb(1'b1, sifd_pkg::ADDR_CTRL, 32'(r));
      pins(9'h1);
      chk(step, r ? 32'h0001_2345 : 32'h0);
      pins(9'h0);
      chk(step, 32'h0);
    end
    $display("step test done");
    wb(1'b1, sifd_pkg::ADDR_VCAP1, 32'h0abc);
    wb(1'b1, sifd_pkg::ADDR_VCAP2, 32'h0def);
    put(0, sifd_pkg::FN_VCAP, sifd_pkg::LOGIC_HIGH);
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, sifd_pkg::ADDR_CTRL, s ? 32'h20 : 32'h0);
      pins(9'h1);
      chk(32'(vcap), s ? 32'h0abc : 32'h0def);
      pins(9'h0);
      chk(32'(vcap), 32'h0def);
    end
    $display("speed cap test done");
    put(0, sifd_pkg::FN_SEARCH, sifd_pkg::LOGIC_RISE);
    pins(9'h1);
    pins(9'h0);
    pins(9'h1);
    chk(32'(n_starts), 32'h1);
    chk(32'(cmd.searching), 32'h1);
    done_p <= 1'b1;
    @(posedge clk);
    done_p <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(cmd.searching), 32'h0);
    wb(1'b1, 8'h80, 32'hffff_ffff);
    wb(1'b0, 8'h80, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, sifd_pkg::ADDR_STEP, 32'h0);
    chk(q, 32'h0001_2345);
    wb(1'b0, sifd_pkg::ADDR_VCAP1, 32'h0);
    chk(q, 32'h0000_0abc);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0000_0220);
    $display("search and bus test done");
    // terminal 0 unlocks, terminal 1 inhibits the on-the-fly latch
    put(0, sifd_pkg::FN_RELEASE, sifd_pkg::LOGIC_HIGH);
    put(1, sifd_pkg::FN_BLOCK, sifd_pkg::LOGIC_HIGH);
    pins(9'h0);
    for (int m = 0; m < 2; m++) begin
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(cmd.move_locked), 32'(m == 0));
      pins(m ? 9'h0 : 9'h1);
      chk(32'(cmd.move_locked), 32'h0);
      pins(9'h2);
    end
    $display("latch test done");
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run;
  end
endmodule
bind sifd_decoder sifd_monitor MON (.clk(clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cmd(cmd), .step_amount(step_amount));
